// [rtl/cdt_regs.svh]
/*
  Constants of the data-transfer decoder: opcodes, register codes,
  flag bit positions, clock-state counts and the pc reset value.
  Assumes one clock state per rising edge of i_clock.
*/
// Operation
// - transfers leave flags alone, except vector/refresh loads
// - register copy: one byte, 4 states
// - register to pointer-pair memory: 7 states
// - pointer-pair memory to register: 7 states
// - indexed load/store with signed displacement: 19 states
// - immediate byte into register: 7 states
// - immediate byte to pointer-pair memory: 10 states
// - indexed immediate store, fourth byte: 19 states
// - accumulator load from absolute address: 13 states
// - accumulator store to absolute address: 13 states
// - indirect accumulator via first two pairs: 7 states
// - vector load: flag from latch, clear H, N
// - refresh load, code 5F, flag from latch
// - accumulator into vector/refresh: 9 states, no flags
// - pair immediate load, low then high: 10
// - index immediate load, bytes three/four: 14 states
// - extended pair load from nn, nn+1: 20
// - pointer pair load from nn, nn+1: 16
// - extended pair store to nn, nn+1: 20
// - pointer pair store to nn, nn+1: 16
// - index direct load/store at nn, nn+1: 20
// - index into stack pointer: 10 states
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH

// ==========================================================
// prefixes and opcodes
`define CDT_PFX_EXT 8'hED
`define CDT_PFX_IX 8'hDD
`define CDT_PFX_IY 8'hFD
`define CDT_OP_ACC_LD 8'h3A
`define CDT_OP_ACC_ST 8'h32
`define CDT_OP_PTR_LD 8'h2A
`define CDT_OP_PTR_ST 8'h22
`define CDT_OP_IMM_MEM 8'h36
`define CDT_OP_IDX_IMM 8'h21
`define CDT_OP_SP_IDX 8'hF9
`define CDT_OP_A_VEC 8'h57
`define CDT_OP_A_RFS 8'h5F
`define CDT_OP_VEC_A 8'h47
`define CDT_OP_RFS_A 8'h4F

// ==========================================================
// register codes
`define CDT_RF_B 3'h0
`define CDT_RF_C 3'h1
`define CDT_RF_D 3'h2
`define CDT_RF_E 3'h3
`define CDT_RF_H 3'h4
`define CDT_RF_L 3'h5
`define CDT_RF_MEM 3'h6
`define CDT_RF_A 3'h7

// ==========================================================
// flag bit positions
`define CDT_FL_S 3'h7
`define CDT_FL_Z 3'h6
`define CDT_FL_H 3'h4
`define CDT_FL_PV 3'h2
`define CDT_FL_N 3'h1

// ==========================================================
// clock states per instruction, then the pc reset value
`define CDT_T4 5'h04
`define CDT_T7 5'h07
`define CDT_T9 5'h09
`define CDT_T10 5'h0A
`define CDT_T13 5'h0D
`define CDT_T14 5'h0E
`define CDT_T16 5'h10
`define CDT_T19 5'h13
`define CDT_T20 5'h14
`define CDT_T_ILL 5'h04
`define CDT_PC_RST 16'h0000

`endif

// [rtl/cdt_pkg.sv]
/*
  Types of the data-transfer decoder.
  Assumes cdt_regs.svh supplies the numeric constants.
*/
package cdt_pkg;
    typedef enum logic [1:0] {PFX_NONE, PFX_EXT, PFX_IX, PFX_IY} cdt_pfx_t;
    typedef enum logic [1:0] {MEM_NONE, MEM_RD, MEM_WR} cdt_mem_t;
    typedef enum logic [2:0] {AS_PTR, AS_IDX, AS_NN, AS_BC, AS_DE} cdt_asel_t;
    typedef struct packed {
        logic legal;
        logic [1:0] nimm;
        cdt_mem_t mem;
        logic two;
        cdt_asel_t asel;
        logic [4:0] tst;
    } cdt_dec_t;
    typedef struct packed {
        logic [7:0] a, f, b, c, d, e, h, l, i, r;
        logic [15:0] ix, iy, sp, pc;
    } cdt_regs_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cdt_mbus_t;
endpackage

// [rtl/cdt_decoder.sv]
/*
  Fetch, decode and execution of the 8- and 16-bit data transfer
  instructions, with the programmer-visible registers.
  Assumes a synchronous byte memory: data read for a request
  standing in cycle k is valid during cycle k+1.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cdt_regs.svh"

module cdt_decoder (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic i_ie_latch,
    input wire logic [7:0] i_mem_rdata,
    output cdt_pkg::cdt_mbus_t o_mbus,
    output cdt_pkg::cdt_regs_t o_regs,
    output logic o_done,
    output logic o_illegal
);
    import cdt_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_FCAP, ST_MEM, ST_MCAP, ST_PAD} cdt_st_t;

    // ==========================================================
    // register access helpers
    function automatic logic [7:0] get8(cdt_regs_t r, logic [2:0] c);
        case (c)
            `CDT_RF_B: get8 = r.b;
            `CDT_RF_C: get8 = r.c;
            `CDT_RF_D: get8 = r.d;
            `CDT_RF_E: get8 = r.e;
            `CDT_RF_H: get8 = r.h;
            `CDT_RF_L: get8 = r.l;
            default: get8 = r.a;
        endcase
    endfunction

    function automatic cdt_regs_t put8(cdt_regs_t r, logic [2:0] c, logic [7:0] v);
        put8 = r;
        case (c)
            `CDT_RF_B: put8.b = v;
            `CDT_RF_C: put8.c = v;
            `CDT_RF_D: put8.d = v;
            `CDT_RF_E: put8.e = v;
            `CDT_RF_H: put8.h = v;
            `CDT_RF_L: put8.l = v;
            `CDT_RF_A: put8.a = v;
            default: put8.a = r.a;
        endcase
    endfunction

    function automatic logic [15:0] getpp(cdt_regs_t r, logic [1:0] pp);
        case (pp)
            2'h0: getpp = {r.b, r.c};
            2'h1: getpp = {r.d, r.e};
            2'h2: getpp = {r.h, r.l};
            default: getpp = r.sp;
        endcase
    endfunction

    function automatic cdt_regs_t putpp(cdt_regs_t r, logic [1:0] pp, logic [15:0] v);
        putpp = r;
        case (pp)
            2'h0: {putpp.b, putpp.c} = v;
            2'h1: {putpp.d, putpp.e} = v;
            2'h2: {putpp.h, putpp.l} = v;
            default: putpp.sp = v;
        endcase
    endfunction

    function automatic logic [15:0] idxv(cdt_regs_t r, cdt_pfx_t p);
        idxv = (p == PFX_IY) ? r.iy : r.ix;
    endfunction

    // ==========================================================
    // decode: operand bytes, memory work and clock states
    function automatic cdt_dec_t decode(cdt_pfx_t p, logic [7:0] op);
        decode = '0;
        decode.legal = 1'b1;
        decode.mem = MEM_NONE;
        decode.asel = AS_PTR;
        decode.tst = `CDT_T_ILL;
        case (p)
            PFX_NONE: begin
                if (op[7:6] == 2'h1) begin
                    if (op[5:3] == `CDT_RF_MEM && op[2:0] == `CDT_RF_MEM) begin
                        decode.legal = 1'b0;
                    end else if (op[2:0] == `CDT_RF_MEM) begin
                        decode.mem = MEM_RD;
                        decode.tst = `CDT_T7;
                    end else if (op[5:3] == `CDT_RF_MEM) begin
                        decode.mem = MEM_WR;
                        decode.tst = `CDT_T7;
                    end else begin
                        decode.tst = `CDT_T4;
                    end
                end else if (op[7:6] == 2'h0 && op[2:0] == `CDT_RF_MEM) begin
                    decode.nimm = 2'h1;
                    if (op[5:3] == `CDT_RF_MEM) begin
                        decode.mem = MEM_WR;
                        decode.tst = `CDT_T10;
                    end else begin
                        decode.tst = `CDT_T7;
                    end
                end else if (op == `CDT_OP_ACC_LD || op == `CDT_OP_ACC_ST) begin
                    decode.nimm = 2'h2;
                    decode.asel = AS_NN;
                    decode.mem = op[3] ? MEM_RD : MEM_WR;
                    decode.tst = `CDT_T13;
                end else if (op == `CDT_OP_PTR_LD || op == `CDT_OP_PTR_ST) begin
                    decode.nimm = 2'h2;
                    decode.asel = AS_NN;
                    decode.two = 1'b1;
                    decode.mem = op[3] ? MEM_RD : MEM_WR;
                    decode.tst = `CDT_T16;
                end else if (op[7:6] == 2'h0 && op[3:0] == 4'h1) begin
                    decode.nimm = 2'h2;
                    decode.tst = `CDT_T10;
                end else if (op[7:5] == 3'h0 && op[2:0] == 3'h2) begin
                    decode.asel = op[4] ? AS_DE : AS_BC;
                    decode.mem = op[3] ? MEM_RD : MEM_WR;
                    decode.tst = `CDT_T7;
                end else begin
                    decode.legal = 1'b0;
                end
            end
            PFX_EXT: begin
                if (op == `CDT_OP_A_VEC || op == `CDT_OP_A_RFS ||
                    op == `CDT_OP_VEC_A || op == `CDT_OP_RFS_A) begin
                    decode.tst = `CDT_T9;
                end else if (op[7:6] == 2'h1 && op[2:0] == 3'h3) begin
                    decode.nimm = 2'h2;
                    decode.asel = AS_NN;
                    decode.two = 1'b1;
                    decode.mem = op[3] ? MEM_RD : MEM_WR;
                    decode.tst = `CDT_T20;
                end else begin
                    decode.legal = 1'b0;
                end
            end
            default: begin
                if (op[7:3] == 5'h0E && op[2:0] != `CDT_RF_MEM) begin
                    decode.nimm = 2'h1;
                    decode.asel = AS_IDX;
                    decode.mem = MEM_WR;
                    decode.tst = `CDT_T19;
                end else if (op[7:6] == 2'h1 && op[2:0] == `CDT_RF_MEM && op[5:3] != `CDT_RF_MEM) begin
                    decode.nimm = 2'h1;
                    decode.asel = AS_IDX;
                    decode.mem = MEM_RD;
                    decode.tst = `CDT_T19;
                end else if (op == `CDT_OP_IMM_MEM) begin
                    decode.nimm = 2'h2;
                    decode.asel = AS_IDX;
                    decode.mem = MEM_WR;
                    decode.tst = `CDT_T19;
                end else if (op == `CDT_OP_IDX_IMM) begin
                    decode.nimm = 2'h2;
                    decode.tst = `CDT_T14;
                end else if (op == `CDT_OP_PTR_LD || op == `CDT_OP_PTR_ST) begin
                    decode.nimm = 2'h2;
                    decode.asel = AS_NN;
                    decode.two = 1'b1;
                    decode.mem = op[3] ? MEM_RD : MEM_WR;
                    decode.tst = `CDT_T20;
                end else if (op == `CDT_OP_SP_IDX) begin
                    decode.tst = `CDT_T10;
                end else begin
                    decode.legal = 1'b0;
                end
            end
        endcase
    endfunction

    // only the vector and refresh loads touch flags; carry is kept
    function automatic logic [7:0] accflags(logic [7:0] f, logic [7:0] v, logic ie);
        accflags = f;
        accflags[`CDT_FL_S] = v[7];
        accflags[`CDT_FL_Z] = (v == 8'h00);
        accflags[`CDT_FL_H] = 1'b0;
        accflags[`CDT_FL_PV] = ie;
        accflags[`CDT_FL_N] = 1'b0;
    endfunction

    // ==========================================================
    // register writeback at the last clock state
    function automatic cdt_regs_t retire(cdt_regs_t r, cdt_pfx_t p, logic [7:0] op,
                                         logic [15:0] imm, logic [15:0] md, logic ie);
        retire = r;
        case (p)
            PFX_NONE: begin
                if (op[7:6] == 2'h1 && op[5:3] != `CDT_RF_MEM) begin
                    retire = put8(r, op[5:3], (op[2:0] == `CDT_RF_MEM) ? md[7:0] : get8(r, op[2:0]));
                end else if (op[7:6] == 2'h0 && op[2:0] == `CDT_RF_MEM && op[5:3] != `CDT_RF_MEM) begin
                    retire = put8(r, op[5:3], imm[7:0]);
                end else if (op == `CDT_OP_ACC_LD || (op[7:5] == 3'h0 && op[3:0] == 4'hA)) begin
                    retire.a = md[7:0];
                end else if (op == `CDT_OP_PTR_LD) begin
                    {retire.h, retire.l} = md;
                end else if (op[7:6] == 2'h0 && op[3:0] == 4'h1) begin
                    retire = putpp(r, op[5:4], imm);
                end
            end
            PFX_EXT: begin
                if (op == `CDT_OP_A_VEC) begin
                    retire.a = r.i;
                    retire.f = accflags(r.f, r.i, ie);
                end else if (op == `CDT_OP_A_RFS) begin
                    retire.a = r.r;
                    retire.f = accflags(r.f, r.r, ie);
                end else if (op == `CDT_OP_VEC_A) begin
                    retire.i = r.a;
                end else if (op == `CDT_OP_RFS_A) begin
                    retire.r = r.a;
                end else if (op[3]) begin
                    retire = putpp(r, op[5:4], md);
                end
            end
            default: begin
                if (op[7:6] == 2'h1 && op[5:3] != `CDT_RF_MEM && op[2:0] == `CDT_RF_MEM) begin
                    retire = put8(r, op[5:3], md[7:0]);
                end else if (op == `CDT_OP_IDX_IMM || op == `CDT_OP_PTR_LD) begin
                    if (p == PFX_IY) begin
                        retire.iy = (op == `CDT_OP_PTR_LD) ? md : imm;
                    end else begin
                        retire.ix = (op == `CDT_OP_PTR_LD) ? md : imm;
                    end
                end else if (op == `CDT_OP_SP_IDX) begin
                    retire.sp = idxv(r, p);
                end
            end
        endcase
    endfunction

    // ==========================================================
    // state
    cdt_st_t st_ff, nxt_st;
    cdt_regs_t regs_ff, nxt_regs;
    cdt_mbus_t mbus_ff, nxt_mbus;
    cdt_pfx_t pfx_ff, nxt_pfx;
    logic [7:0] op_ff, nxt_op;
    logic [15:0] imm_ff, nxt_imm;
    logic [15:0] md_ff, nxt_md;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [1:0] icnt_ff, nxt_icnt;
    logic have_op_ff, nxt_have_op;
    logic mcnt_ff, nxt_mcnt;
    logic done_ff, nxt_done;
    logic ill_ff, nxt_ill;
    logic begin_ins;

    wire logic is_prefix = (i_mem_rdata == `CDT_PFX_EXT) || (i_mem_rdata == `CDT_PFX_IX) ||
                           (i_mem_rdata == `CDT_PFX_IY);
    wire cdt_pfx_t pfx_of = (i_mem_rdata == `CDT_PFX_EXT) ? PFX_EXT :
                            (i_mem_rdata == `CDT_PFX_IX) ? PFX_IX : PFX_IY;
    wire cdt_dec_t dnew = decode(pfx_ff, i_mem_rdata);
    wire cdt_dec_t dcur = decode(pfx_ff, op_ff);
    wire logic last_st = (cnt_ff >= dcur.tst - 5'h01);

    // ==========================================================
    // sequencing: fetch bytes, then memory bytes, then pad to the state count
    always_comb begin
        nxt_st = st_ff;
        nxt_regs = regs_ff;
        nxt_pfx = pfx_ff;
        nxt_op = op_ff;
        nxt_imm = imm_ff;
        nxt_md = md_ff;
        nxt_icnt = icnt_ff;
        nxt_have_op = have_op_ff;
        nxt_mcnt = mcnt_ff;
        nxt_cnt = cnt_ff + 5'h01;
        nxt_done = 1'b0;
        nxt_ill = 1'b0;
        begin_ins = 1'b0;
        case (st_ff)
            ST_IDLE: begin
                begin_ins = i_run;
            end
            ST_FETCH: begin
                nxt_st = ST_FCAP;
            end
            ST_FCAP: begin
                nxt_regs.pc = regs_ff.pc + 16'h0001;
                if (!have_op_ff && pfx_ff == PFX_NONE && is_prefix) begin
                    nxt_pfx = pfx_of;
                    nxt_st = ST_FETCH;
                end else if (!have_op_ff) begin
                    nxt_op = i_mem_rdata;
                    nxt_have_op = 1'b1;
                    nxt_st = (dnew.legal && dnew.nimm != 2'h0) ? ST_FETCH :
                             (dnew.legal && dnew.mem != MEM_NONE) ? ST_MEM : ST_PAD;
                end else begin
                    // low byte (or displacement) first, high byte (or data) second
                    if (icnt_ff == 2'h0) begin
                        nxt_imm[7:0] = i_mem_rdata;
                    end else begin
                        nxt_imm[15:8] = i_mem_rdata;
                    end
                    nxt_icnt = icnt_ff + 2'h1;
                    nxt_st = (icnt_ff + 2'h1 < dcur.nimm) ? ST_FETCH :
                             (dcur.mem != MEM_NONE) ? ST_MEM : ST_PAD;
                end
            end
            ST_MEM: begin
                nxt_st = ST_MCAP;
            end
            ST_MCAP: begin
                if (dcur.mem == MEM_RD) begin
                    if (mcnt_ff) begin
                        nxt_md[15:8] = i_mem_rdata;
                    end else begin
                        nxt_md[7:0] = i_mem_rdata;
                    end
                end
                nxt_mcnt = 1'b1;
                nxt_st = (dcur.two && !mcnt_ff) ? ST_MEM : ST_PAD;
            end
            ST_PAD: begin
                if (last_st) begin
                    nxt_done = 1'b1;
                    nxt_ill = !dcur.legal;
                    // flags change only inside retire for the two accumulator loads
                    if (dcur.legal) begin
                        nxt_regs = retire(regs_ff, pfx_ff, op_ff, imm_ff, md_ff, i_ie_latch);
                    end
                    begin_ins = i_run;
                    nxt_st = ST_IDLE;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        if (begin_ins) begin
            nxt_st = ST_FETCH;
            nxt_cnt = 5'h00;
            nxt_pfx = PFX_NONE;
            nxt_have_op = 1'b0;
            nxt_icnt = 2'h0;
            nxt_mcnt = 1'b0;
        end
    end

    // ==========================================================
    // memory request for the coming cycle, built from next-state values
    wire cdt_dec_t dn = decode(nxt_pfx, nxt_op);
    wire logic [15:0] idx_n = idxv(nxt_regs, nxt_pfx);
    wire logic [15:0] disp = {{8{nxt_imm[7]}}, nxt_imm[7:0]};
    wire logic [15:0] base_n = (dn.asel == AS_IDX) ? idx_n + disp :
                               (dn.asel == AS_NN) ? nxt_imm :
                               (dn.asel == AS_BC) ? {nxt_regs.b, nxt_regs.c} :
                               (dn.asel == AS_DE) ? {nxt_regs.d, nxt_regs.e} :
                               {nxt_regs.h, nxt_regs.l};
    // second byte of a 16-bit move sits at nn+1
    wire logic [15:0] daddr = base_n + {15'h0000, nxt_mcnt};
    wire logic [15:0] wpair = (nxt_pfx == PFX_IX || nxt_pfx == PFX_IY) ? idx_n :
                              (nxt_pfx == PFX_EXT) ? getpp(nxt_regs, nxt_op[5:4]) :
                              {nxt_regs.h, nxt_regs.l};
    wire logic [7:0] wbyte = dn.two ? (nxt_mcnt ? wpair[15:8] : wpair[7:0]) :
                             (nxt_op == `CDT_OP_IMM_MEM) ?
                             ((nxt_pfx == PFX_NONE) ? nxt_imm[7:0] : nxt_imm[15:8]) :
                             (nxt_op[7:6] == 2'h1) ? get8(nxt_regs, nxt_op[2:0]) : nxt_regs.a;
    wire logic to_mem = (nxt_st == ST_MEM);
    wire logic to_fetch = (nxt_st == ST_FETCH);

    always_comb begin
        nxt_mbus.rd = to_fetch || (to_mem && dn.mem == MEM_RD);
        nxt_mbus.wr = to_mem && dn.mem == MEM_WR;
        nxt_mbus.addr = to_fetch ? nxt_regs.pc : (to_mem ? daddr : 16'h0000);
        nxt_mbus.wdata = nxt_mbus.wr ? wbyte : 8'h00;
    end

    // ==========================================================
    // flops
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_ff <= ST_IDLE;
            regs_ff <= '0;
            regs_ff.pc <= `CDT_PC_RST;
            mbus_ff <= '0;
            pfx_ff <= PFX_NONE;
            op_ff <= 8'h00;
            imm_ff <= 16'h0000;
            md_ff <= 16'h0000;
            cnt_ff <= 5'h00;
            icnt_ff <= 2'h0;
            have_op_ff <= 1'b0;
            mcnt_ff <= 1'b0;
            done_ff <= 1'b0;
            ill_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            regs_ff <= nxt_regs;
            mbus_ff <= nxt_mbus;
            pfx_ff <= nxt_pfx;
            op_ff <= nxt_op;
            imm_ff <= nxt_imm;
            md_ff <= nxt_md;
            cnt_ff <= nxt_cnt;
            icnt_ff <= nxt_icnt;
            have_op_ff <= nxt_have_op;
            mcnt_ff <= nxt_mcnt;
            done_ff <= nxt_done;
            ill_ff <= nxt_ill;
        end
    end

    assign o_mbus = mbus_ff;
    assign o_regs = regs_ff;
    assign o_done = done_ff;
    assign o_illegal = ill_ff;
endmodule

`default_nettype wire

// [verification/cdt_props.sv]
/*
  Port checker of cdt_decoder, bound to every instance.
  Assumes the single clock domain and synchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module cdt_props (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire cdt_pkg::cdt_mbus_t o_mbus,
    input wire cdt_pkg::cdt_regs_t o_regs,
    input wire logic o_done,
    input wire logic o_illegal
);
    import cdt_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // memory bus
    rw_excl_a: assert property (!(o_mbus.rd && o_mbus.wr)) else $error("read and write together");
    bus_gap_a: assert property ((o_mbus.rd || o_mbus.wr) |=> !(o_mbus.rd || o_mbus.wr)) else $error("bus too dense");
    addr_idle_a: assert property (!(o_mbus.rd || o_mbus.wr) |-> o_mbus.addr == 16'h0000) else $error("addr not idle");
    wdata_idle_a: assert property (!o_mbus.wr |-> o_mbus.wdata == 8'h00) else $error("wdata not idle");
    // ==========================================================
    // completion and register writeback
    done_pulse_a: assert property (o_done |=> !o_done) else $error("done too long");
    ill_done_a: assert property (o_illegal |-> o_done) else $error("illegal without done");
    fetch_next_a: assert property (o_done && $past(i_run) |-> o_mbus.rd) else $error("no back to back fetch");
    flag_hold_a: assert property ($changed(o_regs.f) |-> o_done) else $error("flags moved");
    reg_hold_a: assert property ($changed({o_regs[143:136], o_regs[127:16]}) |-> o_done)
        else $error("register moved outside writeback");
    pc_step_a: assert property ($changed(o_regs.pc) |-> o_regs.pc == $past(o_regs.pc) + 16'h0001)
        else $error("pc jumped");
    cover property (o_mbus.wr);
    cover property (o_done && o_mbus.rd == 1'b0);
    cover property ($changed(o_regs.f));
endmodule

bind cdt_decoder cdt_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_run(i_run), .o_mbus(o_mbus),
    .o_regs(o_regs), .o_done(o_done), .o_illegal(o_illegal));

`default_nettype wire

// [verification/cdt_mem_model.sv]
/*
  Byte memory answering reads one cycle after the request.
  Assumes the bench preloads ram by hierarchical writes.
*/
`timescale 1ns/1ps
`default_nettype none

module cdt_mem_model (
    input wire logic i_clock,
    input wire cdt_pkg::cdt_mbus_t i_mbus,
    output logic [7:0] o_rdata
);
    logic [7:0] ram [0:65535];
    initial o_rdata = 8'h5A;
    // data line toggles when not answering, so a late sample never looks valid
    always @(posedge i_clock) begin
        if (i_mbus.wr)
            ram[i_mbus.addr] <= i_mbus.wdata;
        o_rdata <= i_mbus.rd ? ram[i_mbus.addr] : ~o_rdata;
    end
endmodule

`default_nettype wire

// [verification/test_cdt_decoder.sv]
/*
  Self-checking bench of cdt_decoder, one task a scenario.
  Assumes cdt_mem_model on the memory port.
*/
`timescale 1ns/1ps
`default_nettype none

module test_cdt_decoder;
    import cdt_pkg::*;
    logic clock, rst_n, run, ie, done, ill, sill;
    logic [7:0] rdata;
    logic [15:0] pc;
    logic [63:0] rfv, pv;
    cdt_mbus_t mbus;
    cdt_regs_t regs;
    int failures, checks, d;
    assign rfv = {regs.a, 8'h00, regs.l, regs.h, regs.e, regs.d, regs.c, regs.b};
    assign pv = {regs.sp, regs.h, regs.l, regs.d, regs.e, regs.b, regs.c};
    cdt_decoder dut (.i_clock(clock), .i_rst_n(rst_n), .i_run(run), .i_ie_latch(ie), .i_mem_rdata(rdata),
        .o_mbus(mbus), .o_regs(regs), .o_done(done), .o_illegal(ill));
    cdt_mem_model mem (.i_clock(clock), .i_mbus(mbus), .o_rdata(rdata));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ==========================================================
    // helpers
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string nm);
        checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one instruction at pc, run alone so its length is measured exactly
    task automatic ex(input logic [31:0] c, input int n, input int ts);
        int k;
        for (k = 0; k < n; k++)
            mem.ram[pc + 16'(k)] = c[8*(n-1-k) +: 8];
        @(posedge clock);
        #1 run = 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            #1 k++;
        end while (mbus.rd !== 1'b1 && k < 20);
        run = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 40) begin
            @(posedge clock);
            #1 k++;
        end
        sill = ill;
        chk(16'(k), 16'(ts), "states");
        @(posedge clock);
        #1 pc += 16'(n);
        chk(regs.pc, pc, "pc");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        for (d = 0; d < 8; d++) if (d != 6) begin
            ex({16'h0, 8'h06 | 8'(d << 3), 8'h10 + 8'(d)}, 2, 7);
            chk(rfv[8*d +: 8], 16'h10 + 16'(d), "imm");
        end
        for (d = 1; d < 8; d++) if (d != 6) begin
            ex({24'h0, 8'h40 | 8'(d << 3)}, 1, 4);
            chk(rfv[8*d +: 8], 16'h10, "copy");
        end
        $display("t_regs done");
    endtask
    task automatic t_pair;
        for (d = 0; d < 4; d++) begin
            ex({8'h0, 8'h01 | 8'(d << 4), 8'(2 * d), 8'h30}, 3, 10);
            chk(pv[16*d +: 16], 16'h3000 + 16'(2 * d), "pair");
        end
        $display("t_pair done");
    endtask
    task automatic t_mem;
        ex(32'h70, 1, 7);
        chk(mem.ram[16'h3004], 16'h30, "st hl");
        ex(32'h36A5, 2, 10);
        chk(mem.ram[16'h3004], 16'hA5, "imm hl");
        ex(32'h7E, 1, 7);
        chk(regs.a, 16'hA5, "ld hl");
        ex(32'h02, 1, 7);
        chk(mem.ram[16'h3000], 16'hA5, "st bc");
        ex(32'h1A, 1, 7);
        chk(regs.a, 16'h5C, "ld de");
        $display("t_mem done");
    endtask
    task automatic t_idx;
        ex(32'hDD210031, 4, 14);
        ex(32'hFD210032, 4, 14);
        chk(regs.ix ^ regs.iy, 16'h0300, "idx imm");
        ex(32'hDD70FE, 3, 19);
        chk(mem.ram[16'h30FE], 16'h30, "st idx");
        ex(32'hFD5E05, 3, 19);
        chk(regs.e, 16'h3C, "ld idx");
        ex(32'hDD367F99, 4, 19);
        chk(mem.ram[16'h317F], 16'h99, "imm idx");
        ex(32'hFDF9, 2, 10);
        chk(regs.sp, 16'h3200, "sp idx");
        $display("t_idx done");
    endtask
    task automatic t_dir;
        ex(32'h320034, 3, 13);
        chk(mem.ram[16'h3400], 16'h5C, "st a");
        ex(32'h220234, 3, 16);
        chk({mem.ram[16'h3403], mem.ram[16'h3402]}, 16'h3004, "st hl nn");
        ex(32'h2A0035, 3, 16);
        chk({regs.h, regs.l}, 16'hBEEF, "ld hl nn");
        ex(32'h3A0135, 3, 13);
        chk(regs.a, 16'hBE, "ld a");
        ex(32'hED430436, 4, 20);
        chk({mem.ram[16'h3605], mem.ram[16'h3604]}, 16'h3000, "st bc nn");
        ex(32'hED5B0035, 4, 20);
        chk({regs.d, regs.e}, 16'hBEEF, "ld de nn");
        ex(32'hDD220836, 4, 20);
        chk({mem.ram[16'h3609], mem.ram[16'h3608]}, 16'h3100, "st ix nn");
        ex(32'hFD2A0035, 4, 20);
        chk(regs.iy, 16'hBEEF, "ld iy nn");
        chk(regs.f, 16'h00, "flags");
        chk(16'(sill), 16'h0, "ill");
        $display("t_dir done");
    endtask
    task automatic t_vec;
        ex(32'hED47, 2, 9);
        ex(32'hED4F, 2, 9);
        chk({regs.i, regs.r}, 16'hBEBE, "vec rfs");
        ie = 1'b1;
        ex(32'hED57, 2, 9);
        chk({regs.a, regs.f}, 16'hBE84, "a vec");
        ex(32'h3E00, 2, 7);
        ex(32'hED4F, 2, 9);
        ie = 1'b0;
        ex(32'hED5F, 2, 9);
        chk({regs.a, regs.f}, 16'h0040, "a rfs");
        ex(32'h76, 1, 4);
        chk(16'(sill), 16'h1, "ill");
        $display("t_vec done");
    endtask
    initial begin
        #1000000;
        failures++;
        tally_and_finish;
    end
    initial begin
        {rst_n, run, ie, pc, failures, checks} = '0;
        mem.ram[16'h3002] = 8'h5C;
        mem.ram[16'h3205] = 8'h3C;
        mem.ram[16'h3500] = 8'hEF;
        mem.ram[16'h3501] = 8'hBE;
        repeat (20) @(posedge clock);
        #1 rst_n = 1'b1;
        t_regs;
        t_pair;
        t_mem;
        t_idx;
        t_dir;
        t_vec;
        tally_and_finish;
    end
endmodule

`default_nettype wire
